// >>> hdl/pot_pkg.sv
// ****************************************
// Pattern output trigger constants
// ****************************************
package pot_pkg;

  // Widths and counts
  localparam int POT_ADDR_W = 28;
  localparam int POT_DATA_W = 8;
  localparam int POT_GRP_W  = 4;
  localparam int POT_NGRP   = 4;
  localparam int POT_SEL_W  = 2;
  localparam int POT_NCH    = 4;
  localparam int POT_PIN_W  = POT_GRP_W * POT_NGRP;

  // Register offsets, byte addresses as printed
  localparam logic [POT_ADDR_W-1:0] POT_OFS_NOV       = 28'h5fffff0;
  localparam logic [POT_ADDR_W-1:0] POT_OFS_TRIG      = 28'h5fffff1;
  localparam logic [POT_ADDR_W-1:0] POT_OFS_EN_HI     = 28'h5fffff2;
  localparam logic [POT_ADDR_W-1:0] POT_OFS_EN_LO     = 28'h5fffff3;
  localparam logic [POT_ADDR_W-1:0] POT_OFS_ND_SHARED = 28'h05ffff5;
  localparam logic [POT_ADDR_W-1:0] POT_OFS_ND_SPARE  = 28'h05ffff7;
  localparam logic [POT_ADDR_W-1:0] POT_OFS_ND_G1     = 28'h5fffff5;
  localparam logic [POT_ADDR_W-1:0] POT_OFS_ND_G0     = 28'h5fffff7;

  // Field positions
  localparam int POT_GRP1_LSB = 4;
  localparam int POT_GRP0_LSB = 0;

  // Reset values
  localparam logic [7:0] POT_TRIG_RST = 8'hff;
  localparam logic [7:0] POT_EN_RST   = 8'h00;
  localparam logic [7:0] POT_ND_RST   = 8'h00;
  localparam logic [3:0] POT_NOV_RST  = 4'h0;
  localparam logic [15:0] POT_OUT_RST = 16'h0000;

  // Reserved read values
  localparam logic [7:0] POT_RSVD_BYTE = 8'hff;
  localparam logic [3:0] POT_RSVD_NIB  = 4'hf;
  localparam logic [7:0] POT_RD_IDLE   = 8'h00;

  // Register port request
  typedef struct packed {
    logic [POT_ADDR_W-1:0] addr;
    logic [POT_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } pot_bus_s;

  // Timer compare strobes, one bit per channel
  typedef struct packed {
    logic [POT_NCH-1:0] cmp_a;
    logic [POT_NCH-1:0] cmp_b;
  } pot_cmp_s;

endpackage

// >>> hdl/pot_group.sv
`timescale 1ns/100ps

// ****************************************
// One 4-pin output group
// ****************************************
module pot_group
  import pot_pkg::*;
(
  // Trigger choice
  input  wire logic [POT_SEL_W-1:0] sel,
  input  wire logic                 nov,
  input  wire pot_cmp_s             cmp,
  // Data
  input  wire logic [POT_GRP_W-1:0] nd,
  input  wire logic [POT_GRP_W-1:0] en,
  input  wire logic [POT_GRP_W-1:0] cur,
  output logic      [POT_GRP_W-1:0] nxt
);

  logic hit_a;
  logic hit_b;

  // Selected channel strobes
  assign hit_a = cmp.cmp_a[sel];
  assign hit_b = cmp.cmp_b[sel];

  // Next latch value for the group
  always_comb begin
    nxt = cur;
    if (hit_a && !nov) begin
      nxt = (cur & ~en) | (nd & en);  // see RULE12, see RULE13
    end
    if (nov) begin
      if (hit_a) begin
        nxt = nxt & ~(en & ~nd);      // see RULE12
      end
      if (hit_b) begin
        nxt = nxt | (en & nd);        // see RULE12
      end
    end
  end

endmodule

// >>> hdl/pot_regs.sv
// Behaviour
// RULE1: Bits 7,6 of the trigger select register pick the timer channel 0..3 compare match for group 3.
// RULE2: Bits 5,4 of the trigger select register pick the timer channel 0..3 compare match for group 2.
// RULE3: Bits 3,2 of the trigger select register pick the timer channel 0..3 compare match for group 1.
// RULE4: Bits 1,0 of the trigger select register pick the timer channel 0..3 compare match for group 0.
// RULE5: After reset every trigger field holds 11, so all groups follow channel 3.
// RULE6: Each low enable bit lets pin 7..0 take its next data, a zero blocks it, all reset to zero.
// RULE7: Each high enable bit lets pin 15..8 take its next data, a zero blocks it, all reset to zero.
// RULE8: With groups 0 and 1 on one trigger, the shared byte holds group 1 in 7-4 and group 0 in 3-0.
// RULE9: With groups 0 and 1 on one trigger, the spare byte ignores writes and reads all ones.
// RULE10: With different triggers, the group 1 byte holds data in 7-4 and reads ones in 3-0.
// RULE11: With different triggers, the group 0 byte holds data in 3-0 and reads ones in 7-4.
// RULE12: Non-overlap off updates on compare A; on, zeros go out on A and ones on B.
// RULE13: On its trigger a group copies enabled next bits into the latch in one clock.
`timescale 1ns/100ps

module pot_regs
  import pot_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Register port
  input  wire pot_bus_s              bus_req,
  output logic      [POT_DATA_W-1:0] rd_data,
  // Timer compare strobes
  input  wire pot_cmp_s              cmp,
  // Next data for pins 15..8, held outside
  input  wire logic [7:0]            pending_out_high_bits,
  // Port output latch
  output logic      [POT_PIN_W-1:0]  port_b_out_bits
);

  // ****************************************
  // Storage and decode
  // ****************************************

  logic [7:0]            trig_sel_reg;
  logic [3:0]            nov_reg;
  logic [7:0]            xfer_enable_low_bits;
  logic [7:0]            xfer_enable_high_bits;
  logic [7:0]            pending_out_low_bits;
  logic [POT_PIN_W-1:0]  port_b_out_reg;
  logic [POT_PIN_W-1:0]  port_b_out_next;
  logic [POT_DATA_W-1:0] rd_data_reg;
  logic [POT_DATA_W-1:0] rd_data_next;
  logic                  shared_trig;
  logic                  wr_nov;
  logic                  wr_trig;
  logic                  wr_en_hi;
  logic                  wr_en_lo;
  logic                  wr_nd_shared;
  logic                  wr_nd_g1;
  logic                  wr_nd_g0;
  logic [POT_PIN_W-1:0]  nd_all;
  logic [POT_PIN_W-1:0]  en_all;

  // Groups 0 and 1 share one trigger
  assign shared_trig = (trig_sel_reg[3:2] == trig_sel_reg[1:0]);

  // Write decode, layout follows trigger sharing
  assign wr_nov       = bus_req.wr && (bus_req.addr == POT_OFS_NOV);
  assign wr_trig      = bus_req.wr && (bus_req.addr == POT_OFS_TRIG);
  assign wr_en_hi     = bus_req.wr && (bus_req.addr == POT_OFS_EN_HI);
  assign wr_en_lo     = bus_req.wr && (bus_req.addr == POT_OFS_EN_LO);
  assign wr_nd_shared = bus_req.wr && shared_trig && (bus_req.addr == POT_OFS_ND_SHARED);  // see RULE8
  assign wr_nd_g1     = bus_req.wr && !shared_trig && (bus_req.addr == POT_OFS_ND_G1);    // see RULE10
  assign wr_nd_g0     = bus_req.wr && !shared_trig && (bus_req.addr == POT_OFS_ND_G0);    // see RULE11

  // ****************************************
  // Control registers
  // ****************************************

  // Trigger select, all fields start on channel 3
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_sel_reg <= POT_TRIG_RST;           // see RULE5
    end else if (wr_trig) begin
      trig_sel_reg <= bus_req.wdata;
    end
  end

  // Non-overlap mode bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nov_reg <= POT_NOV_RST;
    end else if (wr_nov) begin
      nov_reg <= bus_req.wdata[3:0];
    end
  end

  // Low transfer enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_enable_low_bits <= POT_EN_RST;     // see RULE6
    end else if (wr_en_lo) begin
      xfer_enable_low_bits <= bus_req.wdata;
    end
  end

  // High transfer enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_enable_high_bits <= POT_EN_RST;    // see RULE7
    end else if (wr_en_hi) begin
      xfer_enable_high_bits <= bus_req.wdata;
    end
  end

  // ****************************************
  // Next data for groups 0 and 1
  // ****************************************

  // Whole byte when shared, one nibble per address when split
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_out_low_bits <= POT_ND_RST;
    end else if (wr_nd_shared) begin
      pending_out_low_bits <= bus_req.wdata;  // see RULE8
    end else if (wr_nd_g1) begin
      pending_out_low_bits[POT_GRP1_LSB +: POT_GRP_W] <= bus_req.wdata[POT_GRP1_LSB +: POT_GRP_W];  // see RULE10
    end else if (wr_nd_g0) begin
      pending_out_low_bits[POT_GRP0_LSB +: POT_GRP_W] <= bus_req.wdata[POT_GRP0_LSB +: POT_GRP_W];  // see RULE11
    end
  end

  // ****************************************
  // Read path
  // ****************************************

  // Read mux, unmapped addresses read zero
  always_comb begin
    rd_data_next = POT_RD_IDLE;
    if (bus_req.addr == POT_OFS_NOV) begin
      rd_data_next = {POT_RSVD_NIB, nov_reg};
    end else if (bus_req.addr == POT_OFS_TRIG) begin
      rd_data_next = trig_sel_reg;
    end else if (bus_req.addr == POT_OFS_EN_HI) begin
      rd_data_next = xfer_enable_high_bits;
    end else if (bus_req.addr == POT_OFS_EN_LO) begin
      rd_data_next = xfer_enable_low_bits;
    end else if (shared_trig && bus_req.addr == POT_OFS_ND_SHARED) begin
      rd_data_next = pending_out_low_bits;                             // see RULE8
    end else if (shared_trig && bus_req.addr == POT_OFS_ND_SPARE) begin
      rd_data_next = POT_RSVD_BYTE;                                    // see RULE9
    end else if (!shared_trig && bus_req.addr == POT_OFS_ND_G1) begin
      rd_data_next = {pending_out_low_bits[7:4], POT_RSVD_NIB};        // see RULE10
    end else if (!shared_trig && bus_req.addr == POT_OFS_ND_G0) begin
      rd_data_next = {POT_RSVD_NIB, pending_out_low_bits[3:0]};        // see RULE11
    end
  end

  // Read data for one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= POT_RD_IDLE;
    end else if (bus_req.rd) begin
      rd_data_reg <= rd_data_next;
    end else begin
      rd_data_reg <= POT_RD_IDLE;
    end
  end

  assign rd_data = rd_data_reg;

  // ****************************************
  // Output groups
  // ****************************************

  // Flat views of data and enables
  assign nd_all = {pending_out_high_bits, pending_out_low_bits};
  assign en_all = {xfer_enable_high_bits, xfer_enable_low_bits};

  // One transfer unit per group
  for (genvar g = 0; g < POT_NGRP; g++) begin : g_grp
    pot_group u_grp (
      .sel (trig_sel_reg[POT_SEL_W*g +: POT_SEL_W]),  // see RULE1, see RULE2, see RULE3, see RULE4
      .nov (nov_reg[g]),
      .cmp (cmp),
      .nd  (nd_all[POT_GRP_W*g +: POT_GRP_W]),
      .en  (en_all[POT_GRP_W*g +: POT_GRP_W]),        // see RULE6, see RULE7
      .cur (port_b_out_reg[POT_GRP_W*g +: POT_GRP_W]),
      .nxt (port_b_out_next[POT_GRP_W*g +: POT_GRP_W])
    );
  end

  // Port output latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_b_out_reg <= POT_OUT_RST;
    end else begin
      port_b_out_reg <= port_b_out_next;  // see RULE13
    end
  end

  assign port_b_out_bits = port_b_out_reg;

  // ****************************************
  // Checks
  // ****************************************

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_n);

  logic trig_written;

  // Marks the first trigger select write since reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_written <= 1'b0;
    end else if (wr_trig) begin
      trig_written <= 1'b1;
    end
  end

  sequence s_wr_shared;
    bus_req.wr && shared_trig && bus_req.addr == POT_OFS_ND_SHARED;
  endsequence

  sequence s_rd_spare;
    bus_req.rd && shared_trig && bus_req.addr == POT_OFS_ND_SPARE;
  endsequence

  sequence s_rd_g1;
    bus_req.rd && !shared_trig && bus_req.addr == POT_OFS_ND_G1;
  endsequence

  sequence s_rd_g0;
    bus_req.rd && !shared_trig && bus_req.addr == POT_OFS_ND_G0;
  endsequence

  chk_grp3_trig_copy: assert property (  // see RULE1
    cmp.cmp_a[trig_sel_reg[7:6]] && !nov_reg[3] |=> port_b_out_reg[15:12] ==
      (($past(port_b_out_reg[15:12]) & ~$past(en_all[15:12])) | ($past(nd_all[15:12]) & $past(en_all[15:12]))))
    else $error("group 3 did not follow its selected trigger");

  chk_grp2_trig_copy: assert property (  // see RULE2
    cmp.cmp_a[trig_sel_reg[5:4]] && !nov_reg[2] |=> port_b_out_reg[11:8] ==
      (($past(port_b_out_reg[11:8]) & ~$past(en_all[11:8])) | ($past(nd_all[11:8]) & $past(en_all[11:8]))))
    else $error("group 2 did not follow its selected trigger");

  chk_grp1_trig_copy: assert property (  // see RULE3
    cmp.cmp_a[trig_sel_reg[3:2]] && !nov_reg[1] |=> port_b_out_reg[7:4] ==
      (($past(port_b_out_reg[7:4]) & ~$past(en_all[7:4])) | ($past(nd_all[7:4]) & $past(en_all[7:4]))))
    else $error("group 1 did not follow its selected trigger");

  chk_grp0_trig_copy: assert property (  // see RULE4
    cmp.cmp_a[trig_sel_reg[1:0]] && !nov_reg[0] |=> port_b_out_reg[3:0] ==
      (($past(port_b_out_reg[3:0]) & ~$past(en_all[3:0])) | ($past(nd_all[3:0]) & $past(en_all[3:0]))))
    else $error("group 0 did not follow its selected trigger");

  chk_trig_reset_val: assert property (  // see RULE5
    !trig_written |-> trig_sel_reg == 8'hff)
    else $error("trigger select left its reset value without a write");

  chk_low_gate: assert property (  // see RULE6
    ((port_b_out_reg[7:0] ^ $past(port_b_out_reg[7:0])) & ~$past(xfer_enable_low_bits)) == 8'h00)
    else $error("disabled low pin changed");

  chk_high_gate: assert property (  // see RULE7
    ((port_b_out_reg[15:8] ^ $past(port_b_out_reg[15:8])) & ~$past(xfer_enable_high_bits)) == 8'h00)
    else $error("disabled high pin changed");

  chk_shared_write: assert property (  // see RULE8
    s_wr_shared |=> pending_out_low_bits == $past(bus_req.wdata))
    else $error("shared next data byte not stored");

  chk_spare_reads_ones: assert property (  // see RULE9
    s_rd_spare |=> rd_data == 8'hff)
    else $error("spare byte did not read all ones");

  chk_g1_split_read: assert property (  // see RULE10
    s_rd_g1 |=> rd_data == {$past(pending_out_low_bits[7:4]), 4'hf})
    else $error("group 1 split byte read wrong");

  chk_g0_split_read: assert property (  // see RULE11
    s_rd_g0 |=> rd_data == {4'hf, $past(pending_out_low_bits[3:0])})
    else $error("group 0 split byte read wrong");

  chk_nov_no_fall_b: assert property (  // see RULE12
    nov_reg[0] && cmp.cmp_b[trig_sel_reg[1:0]] && !cmp.cmp_a[trig_sel_reg[1:0]]
      |=> (~port_b_out_reg[3:0] & $past(port_b_out_reg[3:0])) == 4'h0)
    else $error("non-overlap compare B cleared a pin");

  chk_idle_hold: assert property (  // see RULE13
    cmp == '0 |=> $stable(port_b_out_reg))
    else $error("output latch moved without a trigger");

endmodule

// >>> verif/pot_timer_model.sv
`timescale 1ns/100ps

// ****************************************
// Timer compare strobe model
// ****************************************
module pot_timer_model
  import pot_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Requested strobes and answer delay
  input  wire pot_cmp_s   fire,
  input  wire logic [1:0] lag,
  // Strobes to the block
  output pot_cmp_s        cmp
);
  pot_cmp_s pipe_reg [4];

  // Delay line, a slow timer answers later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe_reg <= '{default: '0};
    end else begin
      pipe_reg[0] <= fire;
      for (int k = 1; k < 4; k++) begin
        pipe_reg[k] <= pipe_reg[k-1];
      end
    end
  end

  // One-cycle strobe after lag plus one clocks
  assign cmp = pipe_reg[lag];
endmodule

// >>> verif/pot_regs_test.sv
`timescale 1ns/100ps

// ****************************************
// Pattern output trigger testbench
// ****************************************
module pot_regs_test
  import pot_pkg::*;
;
  logic                  clk;
  logic                  rst_n;
  pot_bus_s              bus_req;
  logic [POT_DATA_W-1:0] rd_data;
  pot_cmp_s              fire;
  pot_cmp_s              cmp;
  logic [1:0]            lag;
  logic [7:0]            pend_hi;
  logic [POT_PIN_W-1:0]  port;
  logic [7:0]            trig_sh, nd_lo;
  logic [3:0]            nov_sh;
  logic [15:0]           en_sh, exp_p;
  int                    n_mismatch, compares, seed;

  pot_regs pot_regs_i (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data), .cmp(cmp),
                       .pending_out_high_bits(pend_hi), .port_b_out_bits(port));
  pot_timer_model pot_timer_model_i (.clk(clk), .rst_n(rst_n), .fire(fire), .lag(lag), .cmp(cmp));

  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Compare helpers
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Register bus cycles
  task automatic wr(input logic [POT_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus_req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic rd_chk(input string nm, input logic [POT_ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clk) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    #1 chk8(nm, e, rd_data);
  endtask

  // Expected latch after one strobe set
  function automatic logic [15:0] calc(input logic [3:0] a, input logic [3:0] b);
    logic [15:0] p;
    logic [15:0] nd;
    logic [1:0]  s;
    p  = exp_p;
    nd = {pend_hi, nd_lo};
    for (int g = 0; g < 4; g++) begin
      s = trig_sh[2*g +: 2];
      for (int i = 4*g; i < 4*g+4; i++) begin
        if (en_sh[i] && nov_sh[g]) begin
          if (a[s] && !nd[i]) p[i] = 1'b0;
          if (b[s] && nd[i]) p[i] = 1'b1;
        end else if (en_sh[i] && a[s]) begin
          p[i] = nd[i];
        end
      end
    end
    return p;
  endfunction

  // Fire strobes through the timer model and check the latch
  task automatic trig(input logic [3:0] a, input logic [3:0] b, input logic [1:0] l);
    @(posedge clk) begin
      lag  <= l;
      fire <= '{cmp_a: a, cmp_b: b};
    end
    @(posedge clk) fire <= '0;
    repeat (int'(l) + 1) @(posedge clk);
    #1 exp_p = calc(a, b);
    chk16("port latch", exp_p, port);
    repeat (4) @(posedge clk);
  endtask

  // Set registers as the shadows say
  task automatic setup();
    wr(POT_OFS_TRIG, trig_sh);
    wr(POT_OFS_EN_HI, en_sh[15:8]);
    wr(POT_OFS_EN_LO, en_sh[7:0]);
    wr(POT_OFS_NOV, {4'h0, nov_sh});
    if (trig_sh[3:2] == trig_sh[1:0]) begin
      wr(POT_OFS_ND_SHARED, nd_lo);
    end else if (nd_lo[0]) begin
      // Foreign nibble inverted, a leaking write shows up
      wr(POT_OFS_ND_G1, {nd_lo[7:4], ~nd_lo[3:0]});
      wr(POT_OFS_ND_G0, {~nd_lo[7:4], nd_lo[3:0]});
    end else begin
      wr(POT_OFS_ND_G0, {~nd_lo[7:4], nd_lo[3:0]});
      wr(POT_OFS_ND_G1, {nd_lo[7:4], ~nd_lo[3:0]});
    end
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end

  // Main sequence
  initial begin
    bus_req = '0;
    fire = '0;
    lag = 2'd0;
    pend_hi = 8'h00;
    rst_n = 1'b0;
    n_mismatch = 0;
    compares = 0;
    seed = $urandom(32'h291b138f);
    trig_sh = 8'hff;
    nov_sh = 4'h0;
    en_sh = 16'h0000;
    nd_lo = 8'h00;
    exp_p = 16'h0000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("trigger select", POT_OFS_TRIG, 8'hff);
    rd_chk("enable high", POT_OFS_EN_HI, 8'h00);
    rd_chk("enable low", POT_OFS_EN_LO, 8'h00);
    rd_chk("shared data", POT_OFS_ND_SHARED, 8'h00);
    rd_chk("non-overlap", POT_OFS_NOV, 8'hf0);
    @(posedge clk) pend_hi <= 8'hff;
    trig(4'hf, 4'h0, 2'd0);
    $display("test reset done");
    en_sh = 16'h000f;
    nd_lo = 8'h05;
    setup();
    trig(4'h8, 4'h0, 2'd0);
    wr(POT_OFS_ND_SPARE, 8'h00);
    rd_chk("spare byte", POT_OFS_ND_SPARE, 8'hff);
    rd_chk("shared after spare", POT_OFS_ND_SHARED, 8'h05);
    rd_chk("unmapped", POT_OFS_ND_G1, 8'h00);
    $display("test walk done");
    // Every select code on every group
    for (int c = 0; c < 4; c++) begin
      trig_sh = {4{c[1:0]}};
      en_sh = 16'hffff;
      nd_lo = 8'(~nd_lo);
      pend_hi <= 8'(~pend_hi);
      setup();
      for (int f = 0; f < 4; f++) begin
        trig(4'(1 << f), 4'h0, 2'(f));
      end
    end
    $display("test codes done");
    // Random traffic
    repeat (150) begin
      trig_sh = 8'($urandom);
      en_sh = 16'($urandom);
      nov_sh = ($urandom % 3 == 0) ? 4'($urandom) : 4'h0;
      nd_lo = 8'($urandom);
      setup();
      rd_chk("non-overlap", POT_OFS_NOV, {4'hf, nov_sh});
      if (trig_sh[3:2] == trig_sh[1:0]) begin
        wr(POT_OFS_ND_SPARE, 8'($urandom));
        rd_chk("shared data", POT_OFS_ND_SHARED, nd_lo);
        rd_chk("spare byte", POT_OFS_ND_SPARE, 8'hff);
      end else begin
        rd_chk("group1 data", POT_OFS_ND_G1, {nd_lo[7:4], 4'hf});
        rd_chk("group0 data", POT_OFS_ND_G0, {4'hf, nd_lo[3:0]});
        rd_chk("unmapped", POT_OFS_ND_SHARED, 8'h00);
      end
      @(posedge clk) pend_hi <= 8'($urandom);
      trig(4'($urandom), 4'($urandom), 2'($urandom));
    end
    $display("test random done");
    print_verdict();
  end
endmodule
